// ==== rtl/sbs_pkg.sv ====
package sbs_pkg;

  // 512K words of address space
  localparam int ADDR_W_DEF = 19;
  localparam int SEED_W     = 2;
  localparam int LANES      = 4;
  localparam int LANE_W     = 8;
  localparam int DATA_W     = LANES * LANE_W;
  localparam int SYNC_W     = 2;

  localparam logic [SEED_W-1:0] COUNT_ZERO = 2'h0;
  localparam logic [SEED_W-1:0] COUNT_STEP = 2'h1;
  localparam logic [LANES-1:0]  ALL_LANES  = 4'hF;
  localparam logic [LANES-1:0]  NO_LANES   = 4'h0;
  // Output enable pin idles high (off) until the synchroniser has seen the pin
  localparam logic [SYNC_W-1:0] SYNC_HIGH  = 2'h3;
  localparam logic [SYNC_W-1:0] SYNC_LOW   = 2'h0;

  typedef enum logic [1:0] {
    ST_DESEL  = 2'h0,
    ST_FIRST  = 2'h1,
    ST_ACTIVE = 2'h3
  } sbs_state_type;

  // Low two bits of the burst address for a given step
  function automatic logic [SEED_W-1:0] burst_low(
    input logic [SEED_W-1:0] seed,
    input logic [SEED_W-1:0] count,
    input logic              interleave
  );
    burst_low = interleave ? (seed ^ count) : SEED_W'(seed + count);
  endfunction : burst_low

  // Lanes written by a cycle's write controls
  function automatic logic [LANES-1:0] lane_mask(
    input logic             global_write_n,
    input logic             byte_write_en_n,
    input logic [LANES-1:0] lane_write_sel_n
  );
    if (!global_write_n) begin
      lane_mask = ALL_LANES;
    end else if (!byte_write_en_n) begin
      lane_mask = ~lane_write_sel_n;
    end else begin
      lane_mask = NO_LANES;
    end
  endfunction : lane_mask

endpackage : sbs_pkg

// ==== rtl/sbs_port.sv ====
`timescale 1ns/10ps

// Notes on behaviour
// - Address registered on a strobe edge when all chip enables are active.
// - Low two address bits seed a 2-bit burst counter for later addresses.
// - Each lane select writes its lane only together with byte write enable.
// - Global write low writes every lane regardless of other write controls.
// - Burst address steps on each selected edge with advance sampled low and no strobe taken.
// - Selected only when enable A low, enable high high, enable B low.
// - Processor strobe ignored whenever enable A is sampled high.
// - Output enable low drives data pins; high releases them as inputs.
// - First clock of a read after deselect keeps outputs off.
// - Processor strobe low captures address and loads counter seed.
// - With both strobes low and enable A low only the processor strobe is acted on.
// - Controller strobe low also captures address and loads counter seed.
// - Outputs off during write data, first clock after deselect, and deselected.
// - Parity lines act as data; each parity bit follows its lane select.
module sbs_port #(
  parameter int ADDR_W = sbs_pkg::ADDR_W_DEF
) (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic [ADDR_W-1:0]           ADDR,
  input  wire logic                        PROC_ADDR_STROBE_N,
  input  wire logic                        CTRL_ADDR_STROBE_N,
  input  wire logic                        BURST_ADVANCE_N,
  input  wire logic                        GLOBAL_WRITE_N,
  input  wire logic                        BYTE_WRITE_EN_N,
  input  wire logic [sbs_pkg::LANES-1:0]   LANE_WRITE_SEL_N,
  input  wire logic                        CHIP_SEL_LOW_A,
  input  wire logic                        CHIP_SEL_HIGH,
  input  wire logic                        CHIP_SEL_LOW_B,
  input  wire logic                        OUTPUT_EN_N,
  input  wire logic                        BURST_ORDER,
  input  wire logic                        SLEEP_REQUEST,
  input  wire logic [sbs_pkg::DATA_W-1:0]  DQ_IN,
  input  wire logic [sbs_pkg::LANES-1:0]   PARITY_LINES_IN,
  output logic      [sbs_pkg::DATA_W-1:0]  DQ_OUT,
  output logic      [sbs_pkg::LANES-1:0]   PARITY_LINES_OUT,
  output logic                             DQ_OE,
  output logic                             SLEEP_ACTIVE
);

  localparam int DEPTH = 2 ** ADDR_W;
  localparam int LW    = sbs_pkg::LANE_W;

  // Storage: no reset, contents are undefined until written
  logic [sbs_pkg::DATA_W-1:0] mem_data [DEPTH];
  logic [sbs_pkg::LANES-1:0]  mem_par  [DEPTH];

  logic [sbs_pkg::SYNC_W-1:0] oe_sync_reg,    oe_sync_next;
  logic [sbs_pkg::SYNC_W-1:0] sleep_sync_reg, sleep_sync_next;
  logic [sbs_pkg::SYNC_W-1:0] order_sync_reg, order_sync_next;

  sbs_pkg::sbs_state_type     state_reg,  state_next;
  logic [ADDR_W-1:0]          base_reg,   base_next;
  logic [sbs_pkg::SEED_W-1:0] count_reg,  count_next;
  logic [sbs_pkg::DATA_W-1:0] dout_reg,   dout_next;
  logic [sbs_pkg::LANES-1:0]  pout_reg,   pout_next;
  logic                       oe_reg,     oe_next;

  logic                       asleep;
  logic                       interleave;
  logic                       proc_take;
  logic                       ctrl_take;
  logic                       strobe;
  logic                       enables_ok;
  logic [sbs_pkg::LANES-1:0]  wr_lanes;
  logic [ADDR_W-1:0]          cur_addr;
  logic [ADDR_W-1:0]          new_addr;

  // Asynchronous pins pass two flops; only the second flop is read by logic
  always_comb begin
    oe_sync_next    = {oe_sync_reg[0], OUTPUT_EN_N};
    sleep_sync_next = {sleep_sync_reg[0], SLEEP_REQUEST};
    order_sync_next = {order_sync_reg[0], BURST_ORDER};
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_sync_reg    <= sbs_pkg::SYNC_HIGH;
      sleep_sync_reg <= sbs_pkg::SYNC_LOW;
      order_sync_reg <= sbs_pkg::SYNC_LOW;
    end else begin
      oe_sync_reg    <= oe_sync_next;
      sleep_sync_reg <= sleep_sync_next;
      order_sync_reg <= order_sync_next;
    end
  end

  always_comb begin
    asleep     = sleep_sync_reg[1];
    interleave = order_sync_reg[1];
    proc_take  = !PROC_ADDR_STROBE_N && !CHIP_SEL_LOW_A && !asleep;
    ctrl_take  = !CTRL_ADDR_STROBE_N && !proc_take && !asleep;
    strobe     = proc_take || ctrl_take;
    enables_ok = !CHIP_SEL_LOW_A && CHIP_SEL_HIGH && !CHIP_SEL_LOW_B;
    // Writes land on the word in effect during the cycle just ended
    if (state_reg != sbs_pkg::ST_DESEL && !asleep) begin
      wr_lanes = sbs_pkg::lane_mask(GLOBAL_WRITE_N, BYTE_WRITE_EN_N,
                                    LANE_WRITE_SEL_N);
    end else begin
      wr_lanes = sbs_pkg::NO_LANES;
    end
    cur_addr = {base_reg[ADDR_W-1:sbs_pkg::SEED_W],
                sbs_pkg::burst_low(base_reg[sbs_pkg::SEED_W-1:0], count_reg,
                                   interleave)};
  end

  always_comb begin
    state_next = state_reg;
    base_next  = base_reg;
    count_next = count_reg;
    if (asleep) begin
      state_next = sbs_pkg::ST_DESEL;
    end else if (strobe) begin
      if (enables_ok) begin
        state_next = (state_reg == sbs_pkg::ST_DESEL) ? sbs_pkg::ST_FIRST
                                                      : sbs_pkg::ST_ACTIVE;
        base_next  = ADDR;
        count_next = sbs_pkg::COUNT_ZERO;
      end else begin
        state_next = sbs_pkg::ST_DESEL;
      end
    end else if (state_reg != sbs_pkg::ST_DESEL) begin
      state_next = sbs_pkg::ST_ACTIVE;
      if (!BURST_ADVANCE_N) begin
        count_next = sbs_pkg::SEED_W'(count_reg + sbs_pkg::COUNT_STEP);
      end
    end
    new_addr  = {base_next[ADDR_W-1:sbs_pkg::SEED_W],
                 sbs_pkg::burst_low(base_next[sbs_pkg::SEED_W-1:0], count_next,
                                    interleave)};
    // Flow-through: the word for the new address is presented right after the edge
    dout_next = mem_data[new_addr];
    pout_next = mem_par[new_addr];
    // Pin OE passes the synchroniser, so it acts two to three clocks late
    oe_next   = !oe_sync_reg[1] && state_next == sbs_pkg::ST_ACTIVE
                && wr_lanes == sbs_pkg::NO_LANES;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= sbs_pkg::ST_DESEL;
      base_reg  <= '0;
      count_reg <= sbs_pkg::COUNT_ZERO;
      dout_reg  <= '0;
      pout_reg  <= sbs_pkg::NO_LANES;
      oe_reg    <= 1'h0;
    end else begin
      state_reg <= state_next;
      base_reg  <= base_next;
      count_reg <= count_next;
      dout_reg  <= dout_next;
      pout_reg  <= pout_next;
      oe_reg    <= oe_next;
    end
  end

  always_ff @(posedge CLK) begin
    for (int i = 0; i < sbs_pkg::LANES; i++) begin
      if (wr_lanes[i]) begin
        mem_data[cur_addr][i*LW +: LW] <= DQ_IN[i*LW +: LW];
        mem_par[cur_addr][i]           <= PARITY_LINES_IN[i];
      end
    end
  end

  always_comb begin
    DQ_OUT           = dout_reg;
    PARITY_LINES_OUT = pout_reg;
    DQ_OE            = oe_reg;
    SLEEP_ACTIVE     = sleep_sync_reg[1];
  end

  proc_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CHIP_SEL_LOW_A && CTRL_ADDR_STROBE_N && state_reg == sbs_pkg::ST_DESEL)
    |=> state_reg == sbs_pkg::ST_DESEL)
    else $error("processor strobe taken with enable A high");

  select_cond_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (strobe && !enables_ok) |=> state_reg == sbs_pkg::ST_DESEL)
    else $error("selected with chip enables inactive");

  addr_capture_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (strobe && enables_ok && !asleep)
    |=> base_reg == $past(ADDR) && count_reg == sbs_pkg::COUNT_ZERO
        && state_reg != sbs_pkg::ST_DESEL)
    else $error("address or burst seed not captured");

  strobe_prio_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N && !CHIP_SEL_LOW_A && !asleep)
    |-> proc_take && !ctrl_take)
    else $error("controller strobe acted on beside processor strobe");

  burst_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_reg != sbs_pkg::ST_DESEL && !strobe && !asleep && !BURST_ADVANCE_N)
    ##1 (!strobe && !asleep && BURST_ADVANCE_N)
    |=> count_reg == sbs_pkg::SEED_W'($past(count_reg, 2) + sbs_pkg::COUNT_STEP))
    else $error("burst counter did not step once");

  lane_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_reg != sbs_pkg::ST_DESEL && !asleep && GLOBAL_WRITE_N)
    |-> wr_lanes == (BYTE_WRITE_EN_N ? sbs_pkg::NO_LANES : ~LANE_WRITE_SEL_N))
    else $error("byte lanes not qualified by byte write enable");

  global_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_reg != sbs_pkg::ST_DESEL && !asleep && !GLOBAL_WRITE_N)
    |-> wr_lanes == sbs_pkg::ALL_LANES)
    else $error("global write missed a lane");

  first_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(state_reg == sbs_pkg::ST_FIRST) |-> !DQ_OE)
    else $error("outputs on in first clock after deselect");

  write_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_lanes != sbs_pkg::NO_LANES || state_next == sbs_pkg::ST_DESEL) |=> !DQ_OE)
    else $error("outputs on during write or deselect");

  oe_follow_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_next == sbs_pkg::ST_ACTIVE && wr_lanes == sbs_pkg::NO_LANES)
    |=> DQ_OE == !$past(oe_sync_reg[1]))
    else $error("outputs do not follow output enable");

  order_a: assert property (@(posedge CLK) disable iff (!RST_N)
    cur_addr[sbs_pkg::SEED_W-1:0] == (interleave
      ? (base_reg[sbs_pkg::SEED_W-1:0] ^ count_reg)
      : sbs_pkg::SEED_W'(base_reg[sbs_pkg::SEED_W-1:0] + count_reg)))
    else $error("burst address out of order");

  keep_lane_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_lanes[0] && !wr_lanes[1])
    |=> mem_data[$past(cur_addr)][LW-1:0] == $past(DQ_IN[LW-1:0])
        && mem_par[$past(cur_addr)][0] == $past(PARITY_LINES_IN[0]))
    else $error("enabled lane not written");

endmodule : sbs_port

// ==== test/sbs_master.sv ====
`timescale 1ns/10ps

module sbs_master #(
  parameter int ADDR_W = 5
) (
  output logic [ADDR_W-1:0] addr,
  output logic              proc_n,
  output logic              ctrl_n,
  output logic              adv_n,
  output logic              gw_n,
  output logic              bwe_n,
  output logic [3:0]        sel_n,
  output logic [2:0]        ce,
  output logic [35:0]       d
);
  initial begin
    {proc_n, ctrl_n, adv_n, gw_n, bwe_n} = 5'h1F;
    addr = '0;
    sel_n = 4'hF;
    ce = 3'h1;
    d = '0;
  end

  // Called just after an edge; everything holds until the next edge
  task automatic drive(input int k, input logic [2:0] c, input int a, input logic av,
                       input logic g, input logic b, input logic [3:0] s,
                       input logic [35:0] v);
    proc_n = !k[0];
    ctrl_n = !k[1];
    ce = c;
    addr = ADDR_W'(a);
    adv_n = av;
    gw_n = g;
    bwe_n = b;
    sel_n = s;
    // Undriven data lines flip, so stale data never looks valid
    d = (g && b) ? ~d : v;
  endtask : drive
endmodule : sbs_master

// ==== test/sync_burst_sram_port_test.sv ====
`timescale 1ns/10ps

module sync_burst_sram_port_test;
  localparam int AW = 5;
  logic          clk, rst_n, oe_n, order, sleep, dq_oe, sleep_act;
  // Reference copy of the two-flop sleep synchroniser
  logic [1:0]    zq = 2'h0;
  logic          proc_n, ctrl_n, adv_n, gw_n, bwe_n;
  logic [AW-1:0] addr;
  logic [3:0]    sel_n, par_out;
  logic [2:0]    ce;
  logic [35:0]   d;
  logic [31:0]   dq_out;
  logic [35:0]   mem [int];
  logic [15:0]   rnd = 16'h0044;
  int            n_errors, n_compared, base, cnt, st, settle;

  sbs_master #(.ADDR_W(AW)) u_m (.addr(addr), .proc_n(proc_n), .ctrl_n(ctrl_n),
    .adv_n(adv_n), .gw_n(gw_n), .bwe_n(bwe_n), .sel_n(sel_n), .ce(ce), .d(d));

  sbs_port #(.ADDR_W(AW)) u_dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .PROC_ADDR_STROBE_N(proc_n), .CTRL_ADDR_STROBE_N(ctrl_n), .BURST_ADVANCE_N(adv_n),
    .GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_EN_N(bwe_n), .LANE_WRITE_SEL_N(sel_n),
    .CHIP_SEL_LOW_A(ce[0]), .CHIP_SEL_HIGH(ce[1]), .CHIP_SEL_LOW_B(ce[2]),
    .OUTPUT_EN_N(oe_n), .BURST_ORDER(order), .SLEEP_REQUEST(sleep),
    .DQ_IN(d[31:0]), .PARITY_LINES_IN(d[35:32]), .DQ_OUT(dq_out),
    .PARITY_LINES_OUT(par_out), .DQ_OE(dq_oe), .SLEEP_ACTIVE(sleep_act));

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] rand16();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction : rand16

  function automatic int at();
    return (base & ~3) | ((order ? base ^ cnt : base + cnt) & 3);
  endfunction : at

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One bus cycle on the port plus the reference model's view of it
  task automatic step(input int k, input logic [2:0] c, input int a, input logic av,
                      input logic g, input logic b, input logic [3:0] s);
    logic [35:0] v, rd;
    logic [3:0]  m;
    int          cur;
    bit          wr;
    bit          zz;
    v = 36'({rand16(), rand16(), rand16()});
    cur = at();
    m = !g ? 4'hF : (!b ? ~s : 4'h0);
    zz = zq[1];
    wr = st != 0 && m != 0 && !zz;
    u_m.drive(k, c, a, av, g, b, s, v);
    @(posedge clk);
    #5;
    zq = {zq[0], sleep};
    if (zz) begin
      st = 0;
    end else if ((k[0] && !c[0]) || k[1]) begin
      st = (c != 3'h2) ? 0 : (st == 0 ? 1 : 2);
      base = a;
      cnt = 0;
    end else if (st != 0) begin
      cnt = (cnt + !av) & 3;
      st = 2;
    end
    rd = mem.exists(at()) ? mem[at()] : 'x;
    if (wr) begin
      if (!mem.exists(cur)) mem[cur] = 'x;
      for (int i = 0; i < 4; i++) begin
        if (m[i]) begin
          mem[cur][8*i+:8] = v[8*i+:8];
          mem[cur][32+i] = v[32+i];
        end
      end
    end
    if (st != 0 && rd !== 36'hX) chk("data", rd, {par_out, dq_out});
    if (settle > 0) settle--;
    else chk("oe", 36'(!oe_n && st == 2 && !wr), 36'(dq_oe));
    chk("sleep", 36'(zq[1]), 36'(sleep_act));
  endtask : step

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    $display("ERROR watchdog expected done seen timeout");
    conclude();
  end

  initial begin
    {rst_n, oe_n, order, sleep} = 4'h0;
    settle = 3;
    repeat (16) @(posedge clk);
    #5 rst_n = 1;
    for (int a = 0; a < 8; a++) begin
      step(2, 3'h2, a, 1, 1, 1, 4'hF);
      step(0, 3'h2, 0, 1, 0, 0, 4'(rand16()));
    end
    $display("fill done");
    for (int i = 0; i < 6; i++) begin
      step(1, 3'h2, i, 1, 1, 1, 4'hF);
      step(0, 3'h2, 0, 1, 1, 0, 4'(rand16()));
      step(0, 3'h2, 0, 1, 1, 1, 4'h0);
    end
    $display("byte writes done");
    for (int o = 0; o < 4; o++) begin
      order = o[0];
      oe_n = o[1];
      settle = 3;
      step(2, 3'h3, 0, 1, 1, 1, 4'hF);
      step(2, 3'h0, 0, 1, 1, 1, 4'hF);
      step(2, 3'h6, 0, 1, 1, 1, 4'hF);
      step(3, 3'h2, 6, 1, 1, 1, 4'hF);
      repeat (4) step(0, 3'h2, 0, 0, 1, 1, 4'hF);
      step(1, 3'h3, 1, 0, 1, 1, 4'hF);
      step(0, 3'h2, 0, 1, 1, 1, 4'hF);
      step(3, 3'h3, 1, 0, 1, 1, 4'hF);
      step(0, 3'h2, 0, 0, 1, 1, 4'hF);
    end
    $display("bursts done");
    // Sleep: strobes and writes are ignored once the synchroniser has seen it
    sleep = 1;
    oe_n = 0;
    settle = 3;
    repeat (6) step(2, 3'h2, 3, 1, 0, 1, 4'hF);
    sleep = 0;
    repeat (3) step(2, 3'h2, 3, 1, 1, 1, 4'hF);
    step(0, 3'h2, 0, 1, 1, 1, 4'hF);
    $display("sleep done");
    conclude();
  end
endmodule : sync_burst_sram_port_test
